// ### rtl/swdp_map.vh
// Register map, field positions and codes of the status word and data pointer block
// Operation
// RL1: 16-bit pointer, whole or as two bytes
// RL2: Status word at D0H, fixed bit order
// RL3: Carry set on carry/borrow, else cleared
// RL4: Carry serves as Boolean bit accumulator
// RL5: Half-carry on nibble carry/borrow, else cleared
// RL6: Bank bits place working registers in 00H-1FH
// RL7: Overflow on signed overflow of add ops
// RL8: Overflow when product exceeds 255
// RL9: Overflow on divide by zero
// RL10: Overflow cleared otherwise by those ops
// RL11: Parity is odd count of accumulator ones
// RL12: User flags are software-only read/write bits
// RL13: Reset clears the whole status word
// RL14: Writes update all bits except parity
`ifndef SWDP_MAP_VH
`define SWDP_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SWDP_ADDR_W        8
`define SWDP_OFF_STATUS    8'hd0
`define SWDP_OFF_DP_LOW    8'h82
`define SWDP_OFF_DP_HIGH   8'h83
`define SWDP_OFF_DP_WORD   8'h84
`define SWDP_OFF_ACC       8'he0

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define SWDP_BIT_CARRY     7
`define SWDP_BIT_HALF      6
`define SWDP_BIT_UF0       5
`define SWDP_BIT_BANK_HI   4
`define SWDP_BIT_BANK_LO   3
`define SWDP_BIT_OVF       2
`define SWDP_BIT_UF1       1
`define SWDP_BIT_PARITY    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SWDP_STATUS_RST    8'h00
`define SWDP_DP_RST        16'h0000
`define SWDP_DP_HI_RST     8'h00
`define SWDP_DP_LO_RST     8'h00
`define SWDP_BANK_RST      5'h00
`define SWDP_ACC_RST       8'h00

// ----------------------------------------------------------------
// Operation codes from the execution datapath
// ----------------------------------------------------------------
`define SWDP_OP_W          4
`define SWDP_OP_NONE       4'h0
`define SWDP_OP_ADD        4'h1
`define SWDP_OP_ADD_CARRY  4'h2
`define SWDP_OP_SUB_BORROW 4'h3
`define SWDP_OP_PRODUCT    4'h4
`define SWDP_OP_DIV        4'h5
`define SWDP_OP_SETC       4'h6
`define SWDP_OP_CLRC       4'h7
`define SWDP_OP_CPLC       4'h8
`define SWDP_OP_ANLC       4'h9
`define SWDP_OP_ORLC       4'ha
`define SWDP_OP_MOVC       4'hb

// ----------------------------------------------------------------
// Misc constants
// ----------------------------------------------------------------
`define SWDP_BANK_SHIFT    3
`define SWDP_PROD_LIMIT    16'h00ff
`define SWDP_BYTE_ZERO     8'h00

`endif

// ### rtl/swdp_alu_flags.v
// Combinational flag computation for arithmetic and Boolean carry operations
`timescale 1ns/1ps
`include "swdp_map.vh"

module swdp_alu_flags (
	input  wire [`SWDP_OP_W-1:0] op_code,
	input  wire [7:0]            op_a,
	input  wire [7:0]            op_b,
	input  wire                  op_bit,
	input  wire                  carry_in,
	input  wire                  half_in,
	input  wire                  ovf_in,
	output reg                   carry_out,
	output reg                   half_out,
	output reg                   ovf_out,
	output reg  [7:0]            result
);

	reg [8:0]  sum9;
	reg [4:0]  sum5;
	reg [15:0] prod;
	reg        cin;

	// ----------------------------------------------------------------
	// Flag and result evaluation
	// ----------------------------------------------------------------
	// Subtraction done as a minus b minus borrow so borrow appears in bit 8
	always @* begin
		sum9      = 9'h000;
		sum5      = 5'h00;
		prod      = 16'h0000;
		cin       = 1'b0;
		carry_out = carry_in;
		half_out  = half_in;
		ovf_out   = ovf_in;
		result    = op_a;
		case (op_code)
			`SWDP_OP_ADD, `SWDP_OP_ADD_CARRY: begin
				cin       = (op_code == `SWDP_OP_ADD_CARRY) ? carry_in : 1'b0;
				sum9      = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
				sum5      = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
				result    = sum9[7:0];
				carry_out = sum9[8]; // RL3
				half_out  = sum5[4]; // RL5
				ovf_out   = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]); // RL7 RL10
			end
			`SWDP_OP_SUB_BORROW: begin
				sum9      = {1'b0, op_a} - {1'b0, op_b} - {8'h00, carry_in};
				sum5      = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, carry_in};
				result    = sum9[7:0];
				carry_out = sum9[8]; // RL3
				half_out  = sum5[4]; // RL5
				ovf_out   = (op_a[7] != op_b[7]) && (sum9[7] != op_a[7]); // RL7 RL10
			end
			// No nibble carry exists here, so both carry flags clear
			`SWDP_OP_PRODUCT: begin
				prod      = op_a * op_b;
				result    = prod[7:0];
				carry_out = 1'b0; // RL3
				half_out  = 1'b0; // RL5
				ovf_out   = (prod > `SWDP_PROD_LIMIT); // RL8 RL10
			end
			`SWDP_OP_DIV: begin
				result    = (op_b == `SWDP_BYTE_ZERO) ? op_a : op_a / op_b;
				carry_out = 1'b0; // RL3
				half_out  = 1'b0; // RL5
				ovf_out   = (op_b == `SWDP_BYTE_ZERO); // RL9 RL10
			end
			// Boolean ops treat carry as a one-bit accumulator
			`SWDP_OP_SETC: carry_out = 1'b1; // RL4
			`SWDP_OP_CLRC: carry_out = 1'b0; // RL4
			`SWDP_OP_CPLC: carry_out = ~carry_in; // RL4
			`SWDP_OP_ANLC: carry_out = carry_in & op_bit; // RL4
			`SWDP_OP_ORLC: carry_out = carry_in | op_bit; // RL4
			`SWDP_OP_MOVC: carry_out = op_bit; // RL4
			default: begin
				result = op_a;
			end
		endcase
	end

endmodule

// ### rtl/swdp_top.v
// Status word and data pointer block with classic Wishbone register access
`timescale 1ns/1ps
`include "swdp_map.vh"

module swdp_top (
	input  wire                    clk,
	input  wire                    rst_b,
	// Wishbone slave
	input  wire                    wb_cyc_i,
	input  wire                    wb_stb_i,
	input  wire                    wb_we_i,
	input  wire [`SWDP_ADDR_W-1:0] wb_adr_i,
	input  wire [3:0]              wb_sel_i,
	input  wire [31:0]             wb_dat_i,
	output reg  [31:0]             wb_dat_o,
	output reg                     wb_ack_o,
	output reg                     wb_err_o,
	// Execution datapath side
	input  wire [`SWDP_OP_W-1:0]   exec_op,
	input  wire [7:0]              exec_a,
	input  wire [7:0]              exec_b,
	input  wire                    exec_bit,
	input  wire                    acc_we,
	input  wire [7:0]              acc_wdata,
	input  wire                    dp_inc,
	output reg  [7:0]              exec_result,
	output reg  [7:0]              processor_status_word,
	output reg  [15:0]             data_pointer,
	output reg  [4:0]              bank_base,
	output reg  [7:0]              acc
);

	// ----------------------------------------------------------------
	// Flag state
	// ----------------------------------------------------------------
	reg        carry_flag;
	reg        half_carry_flag;
	reg        user_flag_zero;
	reg        bank_select_high;
	reg        bank_select_low;
	reg        overflow_flag;
	reg        user_flag_one;
	reg  [7:0] data_pointer_high;
	reg  [7:0] data_pointer_low;

	wire       alu_carry;
	wire       alu_half;
	wire       alu_ovf;
	wire [7:0] alu_result;
	wire       parity_now;
	wire [7:0] status_view;
	wire       bus_req;
	wire       hit_status;
	wire       hit_dp_low;
	wire       hit_dp_high;
	wire       hit_dpw;
	wire       hit_acc;
	wire       hit_any;
	wire       wr_status;
	wire       arith_op;
	wire [15:0] dp_word;
	wire [15:0] next_dp;
	wire [7:0] next_acc;

	// ----------------------------------------------------------------
	// Flag arithmetic
	// ----------------------------------------------------------------
	swdp_alu_flags u_flags (
		.op_code   (exec_op),
		.op_a      (exec_a),
		.op_b      (exec_b),
		.op_bit    (exec_bit),
		.carry_in  (carry_flag),
		.half_in   (half_carry_flag),
		.ovf_in    (overflow_flag),
		.carry_out (alu_carry),
		.half_out  (alu_half),
		.ovf_out   (alu_ovf),
		.result    (alu_result)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Ack drops for one cycle after each answer, so a held request is served again only every other cycle
	assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign hit_status  = (wb_adr_i == `SWDP_OFF_STATUS);
	assign hit_dp_low  = (wb_adr_i == `SWDP_OFF_DP_LOW);
	assign hit_dp_high = (wb_adr_i == `SWDP_OFF_DP_HIGH);
	assign hit_dpw     = (wb_adr_i == `SWDP_OFF_DP_WORD);
	assign hit_acc     = (wb_adr_i == `SWDP_OFF_ACC);
	assign hit_any     = hit_status | hit_dp_low | hit_dp_high | hit_dpw | hit_acc;
	assign wr_status   = bus_req & wb_we_i & hit_status & wb_sel_i[0];
	assign arith_op    = (exec_op == `SWDP_OP_ADD) | (exec_op == `SWDP_OP_ADD_CARRY)
		| (exec_op == `SWDP_OP_SUB_BORROW) | (exec_op == `SWDP_OP_PRODUCT) | (exec_op == `SWDP_OP_DIV);

	// Parity follows the accumulator value continuously
	assign parity_now = ^acc; // RL11 RL14
	assign status_view = {carry_flag, half_carry_flag, user_flag_zero, bank_select_high,
		bank_select_low, overflow_flag, user_flag_one, parity_now}; // RL2
	assign dp_word    = {data_pointer_high, data_pointer_low};

	// ----------------------------------------------------------------
	// Accumulator (parity source)
	// ----------------------------------------------------------------
	// Bus write to the accumulator wins over the datapath in the same cycle
	assign next_acc = (bus_req & wb_we_i & hit_acc & wb_sel_i[0]) ? wb_dat_i[7:0]
		: acc_we ? acc_wdata
		: arith_op ? alu_result
		: acc;

	always @(posedge clk) begin
		if (!rst_b) begin
			acc <= `SWDP_ACC_RST;
		end else begin
			acc <= next_acc;
		end
	end

	// ----------------------------------------------------------------
	// Status word flags
	// ----------------------------------------------------------------
	// A software write covers all writable bits; same-cycle hardware update loses
	always @(posedge clk) begin
		if (!rst_b) begin
			carry_flag       <= 1'b0; // RL13
			half_carry_flag  <= 1'b0; // RL13
			user_flag_zero   <= 1'b0; // RL13
			bank_select_high <= 1'b0; // RL13
			bank_select_low  <= 1'b0; // RL13
			overflow_flag    <= 1'b0; // RL13
			user_flag_one    <= 1'b0; // RL13
		end else if (wr_status) begin
			carry_flag       <= wb_dat_i[`SWDP_BIT_CARRY]; // RL14
			half_carry_flag  <= wb_dat_i[`SWDP_BIT_HALF]; // RL14
			user_flag_zero   <= wb_dat_i[`SWDP_BIT_UF0]; // RL12
			bank_select_high <= wb_dat_i[`SWDP_BIT_BANK_HI]; // RL14
			bank_select_low  <= wb_dat_i[`SWDP_BIT_BANK_LO]; // RL14
			overflow_flag    <= wb_dat_i[`SWDP_BIT_OVF]; // RL14
			user_flag_one    <= wb_dat_i[`SWDP_BIT_UF1]; // RL12
		end else begin
			// User flags are never touched here
			carry_flag      <= alu_carry; // RL3 RL4
			half_carry_flag <= alu_half; // RL5
			overflow_flag   <= alu_ovf; // RL7 RL8 RL9 RL10
		end
	end

	// ----------------------------------------------------------------
	// Data pointer
	// ----------------------------------------------------------------
	// Byte-wide and word-wide views share the same two byte registers
	assign next_dp = dp_word + 16'h0001;

	always @(posedge clk) begin
		if (!rst_b) begin
			data_pointer_high <= `SWDP_DP_HI_RST;
			data_pointer_low  <= `SWDP_DP_LO_RST;
		end else if (bus_req & wb_we_i & hit_dpw) begin
			if (wb_sel_i[1]) data_pointer_high <= wb_dat_i[15:8]; // RL1
			if (wb_sel_i[0]) data_pointer_low  <= wb_dat_i[7:0]; // RL1
		end else if (bus_req & wb_we_i & hit_dp_high & wb_sel_i[0]) begin
			data_pointer_high <= wb_dat_i[7:0]; // RL1
		end else if (bus_req & wb_we_i & hit_dp_low & wb_sel_i[0]) begin
			data_pointer_low <= wb_dat_i[7:0]; // RL1
		end else if (dp_inc) begin
			data_pointer_high <= next_dp[15:8];
			data_pointer_low  <= next_dp[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Status word output lags one cycle behind the flags to keep outputs on flops
	always @(posedge clk) begin
		if (!rst_b) begin
			processor_status_word <= `SWDP_STATUS_RST;
			data_pointer          <= `SWDP_DP_RST;
			bank_base             <= `SWDP_BANK_RST;
			exec_result           <= `SWDP_BYTE_ZERO;
		end else begin
			processor_status_word <= status_view;
			data_pointer          <= dp_word;
			bank_base             <= {bank_select_high, bank_select_low, 3'h0}; // RL6
			exec_result           <= alu_result;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// Unmapped addresses answer with err so software sees the fault
	always @(posedge clk) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req & hit_any;
			wb_err_o <= bus_req & ~hit_any;
			if (bus_req & ~wb_we_i) begin
				wb_dat_o <= hit_status ? {24'h000000, status_view}
					: hit_dp_low ? {24'h000000, data_pointer_low}
					: hit_dp_high ? {24'h000000, data_pointer_high}
					: hit_dpw ? {16'h0000, dp_word}
					: hit_acc ? {24'h000000, acc}
					: 32'h0000_0000;
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

endmodule

// ### verif/swdp_top_monitor.sv
// Port-level checks for the status word and data pointer block
`timescale 1ns/1ps
`include "swdp_map.vh"
module swdp_top_monitor (
	input wire                    clk,
	input wire                    rst_b,
	input wire                    wb_cyc_i,
	input wire                    wb_stb_i,
	input wire                    wb_we_i,
	input wire [`SWDP_ADDR_W-1:0] wb_adr_i,
	input wire [3:0]              wb_sel_i,
	input wire [31:0]             wb_dat_i,
	input wire                    wb_ack_o,
	input wire                    wb_err_o,
	input wire [`SWDP_OP_W-1:0]   exec_op,
	input wire [7:0]              exec_a,
	input wire [7:0]              exec_b,
	input wire                    exec_bit,
	input wire                    dp_inc,
	input wire [7:0]              exec_result,
	input wire [7:0]              processor_status_word,
	input wire [15:0]             data_pointer,
	input wire [4:0]              bank_base,
	input wire [7:0]              acc
);
	// ----
	// Helpers
	// ----
	// A same-cycle software write wins, so hardware flag checks skip it
	wire [7:0]  sw   = processor_status_word;
	wire        take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire        wr   = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SWDP_OFF_STATUS);
	wire [8:0]  sum  = exec_a + exec_b;
	wire [4:0]  hsum = exec_a[3:0] + exec_b[3:0];
	wire        sov  = (exec_a[7] == exec_b[7]) & (sum[7] != exec_a[7]);
	wire        big  = (exec_a * exec_b) > 16'h00ff;
	wire        add  = ~wr & (exec_op == `SWDP_OP_ADD);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// One answer pulse, then a quiet cycle
	sequence s_answer;
		(wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o | wb_err_o);
	endsequence
	a_bus_answer: assert property (take |=> s_answer)
		else $error("bus answer is not one pulse");
	a_carry_add: assert property (add |-> ##2 sw[7] == $past(sum[8], 2))
		else $error("carry wrong after add");
	a_half_add: assert property (add |-> ##2 sw[6] == $past(hsum[4], 2))
		else $error("half carry wrong after add");
	a_ovf_add: assert property (add |-> ##2 sw[2] == $past(sov, 2))
		else $error("overflow wrong after add");
	a_ovf_mul: assert property (~wr && exec_op == `SWDP_OP_PRODUCT |-> ##2 sw[2] == $past(big, 2))
		else $error("overflow wrong after multiply");
	a_result_add: assert property (exec_op == `SWDP_OP_ADD |=> exec_result == $past(sum[7:0]))
		else $error("result byte wrong after add");
	a_pointer_step: assert property (dp_inc && !take |=> ##1 data_pointer == $past(data_pointer) + 16'h0001)
		else $error("data pointer did not step by one");
	a_carry_move: assert property (~wr && exec_op == `SWDP_OP_MOVC |-> ##2 sw[7] == $past(exec_bit, 2))
		else $error("carry not loaded from bit");
	a_parity_acc: assert property ($stable(acc) ##1 $stable(acc) |-> sw[0] == ^acc)
		else $error("parity does not follow accumulator");
	a_bank_base: assert property ($stable(sw[4:3]) |-> bank_base == {sw[4:3], 3'b000})
		else $error("bank base does not match select bits");
	a_status_write: assert property (wr |-> ##2 sw[7:1] == $past(wb_dat_i[7:1], 2))
		else $error("status word write lost");
	a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> sw == 8'h00)
		else $error("status word not cleared by reset");
endmodule
bind swdp_top swdp_top_monitor u_mon (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .exec_op(exec_op), .exec_a(exec_a), .exec_b(exec_b), .exec_bit(exec_bit),
	.dp_inc(dp_inc), .exec_result(exec_result), .processor_status_word(processor_status_word),
	.data_pointer(data_pointer), .bank_base(bank_base), .acc(acc));

// ### verif/swdp_exec_model.sv
// Execution datapath model that feeds operations and accumulator loads
`timescale 1ns/1ps
`include "swdp_map.vh"
module swdp_exec_model (
	input  wire                   clk,
	output logic [`SWDP_OP_W-1:0] exec_op,
	output logic [7:0]            exec_a,
	output logic [7:0]            exec_b,
	output logic                  exec_bit,
	output logic                  acc_we,
	output logic [7:0]            acc_wdata,
	output logic                  dp_inc
);
	// Idle at time zero
	initial begin
		{exec_op, exec_a, exec_b, exec_bit, acc_we, acc_wdata, dp_inc} = '0;
	end
	// One cycle of work; operands then turn inverse so a stale value is never trusted
	task automatic issue(input logic [3:0] op, input logic [7:0] a, b, input logic t, ld, inc);
		@(posedge clk);
		exec_op <= op;
		{exec_a, exec_b, exec_bit, acc_wdata} <= {a, b, t, a};
		{acc_we, dp_inc} <= {ld, inc};
		@(posedge clk);
		{exec_op, acc_we, dp_inc} <= '0;
		{exec_a, exec_b, exec_bit, acc_wdata} <= ~{a, b, t, a};
	endtask
endmodule

// ### verif/swdp_top_tb.sv
// Self-checking bench for the status word and data pointer block
`timescale 1ns/1ps
`include "swdp_map.vh"
module swdp_top_tb;
	typedef struct {logic [31:0] val; logic [31:0] msk; logic err;} swdp_note_t;
	logic       clk, rst_b, cyc, stb, we;
	logic [7:0] adr, b, ep;
	logic [3:0] sel, op;
	logic [31:0] dat, x;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o, wb_err_o, exec_bit, acc_we, dp_inc;
	wire [3:0]  exec_op;
	wire [7:0]  exec_a, exec_b, acc_wdata;
	int         n_mismatch, total_checks, i;
	swdp_note_t nq[$];
	swdp_top uut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.exec_op(exec_op), .exec_a(exec_a), .exec_b(exec_b), .exec_bit(exec_bit), .acc_we(acc_we),
		.acc_wdata(acc_wdata), .dp_inc(dp_inc), .exec_result(), .processor_status_word(), .data_pointer(),
		.bank_base(), .acc());
	swdp_exec_model m (.clk(clk), .exec_op(exec_op), .exec_a(exec_a), .exec_b(exec_b), .exec_bit(exec_bit),
		.acc_we(acc_we), .acc_wdata(acc_wdata), .dp_inc(dp_inc));
	// ----
	// Tasks
	// ----
	// Expected status word after one datapath operation
	function automatic logic [7:0] flg(input logic [3:0] o, input logic [7:0] a, c, input logic t, input logic [7:0] p);
		logic [8:0] s;
		logic [4:0] h;
		logic       ci;
		ci = (o != `SWDP_OP_ADD) & p[7];
		s = (o == `SWDP_OP_SUB_BORROW) ? {1'b0, a} - c - ci : a + c + ci;
		h = (o == `SWDP_OP_SUB_BORROW) ? {1'b0, a[3:0]} - c[3:0] - ci : a[3:0] + c[3:0] + ci;
		if (o == `SWDP_OP_PRODUCT || o == `SWDP_OP_DIV) p[7:6] = 2'b00;
		case (o)
			`SWDP_OP_ADD, `SWDP_OP_ADD_CARRY, `SWDP_OP_SUB_BORROW: begin
				p[7] = s[8];
				p[6] = h[4];
				p[2] = ((a[7] ^ c[7]) == (o == `SWDP_OP_SUB_BORROW)) & (s[7] ^ a[7]);
			end
			`SWDP_OP_PRODUCT: p[2] = (a * c) > 255;
			`SWDP_OP_DIV: p[2] = (c == 8'h00);
			`SWDP_OP_SETC: p[7] = 1'b1;
			`SWDP_OP_CLRC: p[7] = 1'b0;
			`SWDP_OP_CPLC: p[7] = ~p[7];
			`SWDP_OP_ANLC: p[7] = p[7] & t;
			`SWDP_OP_ORLC: p[7] = p[7] | t;
			`SWDP_OP_MOVC: p[7] = t;
			default: ;
		endcase
		return p;
	endfunction
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Single classic cycle; the note is queued before the request goes out
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, k, input logic e);
		int n = 0;
		nq.push_back('{d, k, e});
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		sel <= (a == `SWDP_OFF_DP_WORD) ? 4'h3 : 4'h1;
		do begin
			@(posedge clk);
			n++;
		end while (!(wb_ack_o | wb_err_o) && n < 20);
		{cyc, stb} <= 2'b00;
		if (n >= 20) begin
			n_mismatch++;
			test_done();
		end
	endtask
	// Answer watcher takes the oldest note
	always @(posedge clk) begin
		if (wb_ack_o | wb_err_o) begin
			swdp_note_t n;
			n = nq.pop_front();
			total_checks++;
			if ((wb_dat_o & n.msk) !== (n.val & n.msk) || wb_err_o !== n.err) begin
				n_mismatch++;
				$display("[FAIL] %0t got %h err %b want %h", $time, wb_dat_o, wb_err_o, n.val);
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog sized well past the expected run
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		test_done();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		{rst_b, cyc, stb, we, adr, sel, dat} = '0;
		void'($urandom(77649));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		bus(0, `SWDP_OFF_STATUS, 0, 32'hff, 0);
		bus(0, `SWDP_OFF_DP_WORD, 0, 32'hffff, 0);
		// Every bank code, user flags set, written parity ignored
		for (i = 0; i < 4; i++) begin
			bus(1, `SWDP_OFF_STATUS, {3'b111, i[1:0], 3'b111}, 0, 0);
			bus(0, `SWDP_OFF_STATUS, {3'b111, i[1:0], 3'b110}, 32'hff, 0);
		end
		// Unmapped place is refused both ways
		bus(1, 8'h55, 32'h1, 0, 1);
		bus(0, 8'h55, 0, 0, 1);
		// Pointer as word, as bytes, and stepped by the datapath
		x = $urandom;
		bus(1, `SWDP_OFF_DP_WORD, x[15:0], 0, 0);
		bus(0, `SWDP_OFF_DP_LOW, x[7:0], 32'hff, 0);
		bus(0, `SWDP_OFF_DP_HIGH, x[15:8], 32'hff, 0);
		bus(1, `SWDP_OFF_DP_LOW, ~x[7:0], 0, 0);
		m.issue(`SWDP_OP_NONE, 0, 0, 0, 0, 1);
		bus(0, `SWDP_OFF_DP_WORD, {x[15:8], ~x[7:0]} + 16'h1, 32'hffff, 0);
		// Parity after loads from the bus and from the datapath
		for (i = 0; i < 6; i++) begin
			x = $urandom;
			if (i[0])
				m.issue(`SWDP_OP_NONE, x[7:0], 0, 0, 1, 0);
			else
				bus(1, `SWDP_OFF_ACC, x[7:0], 0, 0);
			bus(0, `SWDP_OFF_STATUS, {31'h0, ^x[7:0]}, 32'h1, 0);
		end
		// Random operations over random starting flags; divisor zero one time in four
		for (i = 0; i < 80; i++) begin
			x = $urandom;
			ep = {x[7:1], 1'b0};
			bus(1, `SWDP_OFF_STATUS, ep, 0, 0);
			op = 4'(1 + $urandom % 11);
			b = x[15:8] & ((x[17:16] == 2'b00) ? 8'h00 : 8'hff);
			m.issue(op, x[31:24], b, x[18], 0, 0);
			ep = flg(op, x[31:24], b, x[18], ep);
			bus(0, `SWDP_OFF_STATUS, ep, 32'hfe, 0);
		end
		// Reset in mid-run clears the status word
		bus(1, `SWDP_OFF_STATUS, 32'hff, 0, 0);
		@(posedge clk) rst_b <= 1'b0;
		@(posedge clk) rst_b <= 1'b1;
		bus(0, `SWDP_OFF_STATUS, 0, 32'hff, 0);
		test_done();
	end
endmodule
